// file: core/aisr_pkg.sv
// Package: register map, field layout, reset values and timing
package aisr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_INT_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TEMP_OUT = 8'h01;
  localparam logic [7:0] ADDR_X_LO = 8'h04;
  localparam logic [7:0] ADDR_X_HI = 8'h05;
  localparam logic [7:0] ADDR_Y_LO = 8'h06;
  localparam logic [7:0] ADDR_Y_HI = 8'h07;
  localparam logic [7:0] ADDR_Z_LO = 8'h08;
  localparam logic [7:0] ADDR_Z_HI = 8'h09;
  localparam logic [7:0] ADDR_VECTOR_MAGNITUDE_OUTPUT_LO = 8'h0A;
  localparam logic [7:0] ADDR_VECTOR_MAGNITUDE_OUTPUT_HI = 8'h0B;
  localparam logic [7:0] ADDR_SENS_CFG1 = 8'h15;
  localparam logic [7:0] ADDR_SENS_CFG3 = 8'h17;
  localparam logic [7:0] ADDR_BUF_CFG1 = 8'h26;
  localparam logic [7:0] ADDR_RSVD_A = 8'h39;
  localparam logic [7:0] ADDR_RSVD_B = 8'h3A;
  localparam logic [7:0] ADDR_FIRST = 8'h00;

  // Status bit positions
  localparam int BIT_NEW_SAMPLE = 7;
  localparam int BIT_OVERRUN = 6;
  localparam int BIT_BUFFER = 5;
  localparam int BIT_OUTSIDE = 4;
  localparam int BIT_WITHIN = 3;
  localparam int BIT_ORIENT = 2;
  localparam int BIT_AUTO_SLEEP = 1;
  localparam int BIT_BOOT = 0;

  // Control field positions
  localparam int BIT_ACTIVATE = 0;
  localparam int BIT_TRIG_SEL = 1;
  localparam int BIT_SOFT_RST = 7;
  localparam int BIT_BYTE_ORDER = 0;
  localparam int BIT_BUF_MODE_LO = 0;
  localparam int BIT_BUF_MODE_HI = 1;
  localparam int BIT_BUF_FLUSH = 7;

  // Values after reset
  localparam logic [7:0] RST_INT_STATUS = 8'h01;
  localparam logic [7:0] RST_RSVD_A = 8'h00;
  localparam logic [7:0] RST_RSVD_B = 8'h00;
  localparam logic [1:0] RST_BUF_MODE = 2'h0;
  localparam logic RST_BYTE_ORDER = 1'b0;

  // Timing
  localparam int CLK_KHZ = 40000;
  localparam int PULSE_US = 5000;
  localparam int PULSE_CYC = (PULSE_US * CLK_KHZ) / 1000;
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

  // Operating modes
  typedef enum logic [2:0]
  {
    AISR_STANDBY = 3'b001,
    AISR_ACTIVE = 3'b010,
    AISR_EXTERNAL_TRIGGER_STATE = 3'b100
  } aisr_mode_t;
endpackage

// file: core/aisr_pulse.sv
// Self-clearing interrupt pulse timer
`timescale 1ns/1ps
module aisr_pulse #(
  parameter int WIDTH_CYC = aisr_pkg::PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic stop,
  output logic pulse_out
);
  localparam int CW = $clog2(WIDTH_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(WIDTH_CYC - 1);

  logic [CW-1:0] count;
  wire at_end = (count == LAST);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pulse_out <= 1'b0;
      count <= '0;
    end
    else if (ce)
    begin
      if (stop)
      begin
        pulse_out <= 1'b0;
        count <= '0;
      end
      else if (start)
      begin
        pulse_out <= 1'b1;
        count <= '0;
      end
      else if (pulse_out)
      begin
        pulse_out <= !at_end;
        count <= at_end ? '0 : count + 1'b1;
      end
    end
  end
endmodule

// file: core/aisr_top.sv
// Interrupt source status, mode control and register tail of the sensor
// Operation
// - Auto-increment goes from first reserved to second, then wraps to zero.
// - Going from active to standby leaves every register unchanged.
// - Power-on, brown-out or hibernate exit restores register defaults.
// - Status flags clear when leaving standby for active or trigger state.
// - Sample bytes are little-endian right or big-endian left justified.
// - Buffer contents marked invalid on leaving standby.
// - Configuration writes only in standby; activate except in trigger state; reset, purge anytime.
// - Writes to the activate bit are ignored in the trigger state.
// - Status byte at zero: eight read-only flags, only boot resets to one.
// - New-sample flag sets when a fresh result set arrives.
// - Reading any axis or magnitude output clears the new-sample flag.
// - Buffer mode nonzero holds the new-sample flag at zero.
// - Strap low: output reads clear the flag, and the interrupt level one cycle later.
// - Strap high: data-ready interrupt is a pulse of the motion width.
// - Entering standby ends a running data-ready pulse at once.
// - Overrun flag sets when new results latch before previous were read.
// - No overrun if an axis register was read before new results.
// - Reading the status register clears the overrun flag.
// - Buffer mode nonzero holds the overrun flag at zero.
`timescale 1ns/1ps
module aisr_top #(
  parameter int PULSE_CYCLES = aisr_pkg::PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic hibernate_exit,
  input wire logic wake_strap,
  input wire logic sample_clk,
  input wire logic [11:0] accel_x,
  input wire logic [11:0] accel_y,
  input wire logic [11:0] accel_z,
  input wire logic [11:0] vector_magnitude_output,
  input wire logic [7:0] temp_data,
  input wire logic buffer_event_in,
  input wire logic outside_threshold_in,
  input wire logic within_threshold_in,
  input wire logic orientation_change_in,
  input wire logic auto_sleep_in,
  input wire logic host_addr_load,
  input wire logic [7:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic [7:0] addr_pointer,
  output logic int_data_ready,
  output logic [2:0] op_mode,
  output logic byte_order_select,
  output logic buffer_flush,
  output logic buffer_invalid
);
  // Byte of a 12-bit result in the selected order
  function automatic logic [7:0] sample_byte(input logic [11:0] d,
                                             input logic hi,
                                             input logic be);
    logic [7:0] b;
    b = 8'h00;
    if (be)
      b = hi ? {d[3:0], 4'h0} : d[11:4];
    else
      b = hi ? {4'h0, d[11:8]} : d[7:0];
    return b;
  endfunction

  function automatic logic is_axis(input logic [7:0] a);
    return (a >= aisr_pkg::ADDR_X_LO) && (a <= aisr_pkg::ADDR_Z_HI);
  endfunction

  function automatic logic is_vector_magnitude_output(input logic [7:0] a);
    return (a == aisr_pkg::ADDR_VECTOR_MAGNITUDE_OUTPUT_LO) || (a == aisr_pkg::ADDR_VECTOR_MAGNITUDE_OUTPUT_HI);
  endfunction

  aisr_pkg::aisr_mode_t mode;
  aisr_pkg::aisr_mode_t next_mode;

  logic activate;
  logic trig_sel;
  logic [1:0] buf_mode;
  logic [7:0] rsvd_a;
  logic soft_rst;
  logic new_sample_flag;
  logic sample_overrun_flag;
  logic boot_complete_flag;
  logic unread_set;
  logic [11:0] lat_x;
  logic [11:0] lat_y;
  logic [11:0] lat_z;
  logic [11:0] lat_vector_magnitude_output;
  logic [7:0] lat_temp;
  logic [2:0] smp_sync;
  logic smp_level;
  logic [2:0] strap_sync;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic wake_high;
  logic pulse_level;
  logic [7:0] rd_mux;
  logic [7:0] next_ptr;

  // Registers lost on any reset source
  wire reg_rst = srst | hibernate_exit | soft_rst;

  wire in_standby = (mode == aisr_pkg::AISR_STANDBY);
  wire in_ext = (mode == aisr_pkg::AISR_EXTERNAL_TRIGGER_STATE);
  wire buf_on = (buf_mode != 2'h0);
  wire leave_standby = in_standby & (next_mode != aisr_pkg::AISR_STANDBY);
  wire enter_standby = !in_standby &
                       (next_mode == aisr_pkg::AISR_STANDBY);

  // Host access decode at the current pointer
  wire acc_rd = host_rd;
  wire acc_wr = host_wr;
  wire wr_cfg1 = acc_wr & (addr_pointer == aisr_pkg::ADDR_SENS_CFG1);
  wire wr_cfg3 = acc_wr & (addr_pointer == aisr_pkg::ADDR_SENS_CFG3);
  wire wr_buf1 = acc_wr & (addr_pointer == aisr_pkg::ADDR_BUF_CFG1);
  wire wr_rsvd_a = acc_wr & (addr_pointer == aisr_pkg::ADDR_RSVD_A);
  wire rd_status = acc_rd & (addr_pointer == aisr_pkg::ADDR_INT_STATUS);
  wire rd_axis = acc_rd & is_axis(addr_pointer);
  wire rd_output = acc_rd & (is_axis(addr_pointer) |
                             is_vector_magnitude_output(addr_pointer));

  // Filtered link level and its rising edge
  wire smp_agree = (smp_sync[1] == smp_sync[2]);
  wire smp_rise = smp_agree & smp_sync[2] & !smp_level;
  wire latch_set = smp_rise & !in_standby;

  // Sticky flags, set wins over clear
  wire next_new_sample = !buf_on & (latch_set |
    (new_sample_flag & !rd_output & !leave_standby));
  wire next_overrun = !buf_on & ((latch_set & unread_set) |
    (sample_overrun_flag & !rd_status & !leave_standby));
  wire next_unread = latch_set |
    (unread_set & !rd_axis & !leave_standby);
  wire next_boot = boot_complete_flag & !rd_status & !leave_standby;

  wire [7:0] status_byte = {new_sample_flag,
                            sample_overrun_flag,
                            buffer_event_in & buf_on,
                            outside_threshold_in,
                            within_threshold_in,
                            orientation_change_in,
                            auto_sleep_in,
                            boot_complete_flag};

  // Pointer: reserved_a to reserved_b, then wrap to the first register
  wire [7:0] inc_ptr = (addr_pointer == aisr_pkg::ADDR_RSVD_B) ?
                       aisr_pkg::ADDR_FIRST :
                       addr_pointer + 8'h01;
  wire acc_any = acc_rd | acc_wr;
  assign next_ptr = host_addr_load ? host_addr :
                    acc_any ? inc_ptr : addr_pointer;

  wire pulse_start = wake_high & latch_set & !buf_on;
  wire next_irq = wake_high ? pulse_level : new_sample_flag;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      aisr_pkg::AISR_STANDBY:
      begin
        if (activate)
          next_mode = trig_sel ? aisr_pkg::AISR_EXTERNAL_TRIGGER_STATE :
                                 aisr_pkg::AISR_ACTIVE;
      end
      aisr_pkg::AISR_ACTIVE:
      begin
        if (!activate)
          next_mode = aisr_pkg::AISR_STANDBY;
      end
      aisr_pkg::AISR_EXTERNAL_TRIGGER_STATE:
        next_mode = aisr_pkg::AISR_EXTERNAL_TRIGGER_STATE;
      default:
        next_mode = aisr_pkg::AISR_STANDBY;
    endcase
  end

  always_comb
  begin
    rd_mux = 8'h00;
    case (addr_pointer)
      aisr_pkg::ADDR_INT_STATUS: rd_mux = status_byte;
      aisr_pkg::ADDR_TEMP_OUT: rd_mux = lat_temp;
      aisr_pkg::ADDR_X_LO: rd_mux = sample_byte(lat_x, 1'b0,
                                                byte_order_select);
      aisr_pkg::ADDR_X_HI: rd_mux = sample_byte(lat_x, 1'b1,
                                                byte_order_select);
      aisr_pkg::ADDR_Y_LO: rd_mux = sample_byte(lat_y, 1'b0,
                                                byte_order_select);
      aisr_pkg::ADDR_Y_HI: rd_mux = sample_byte(lat_y, 1'b1,
                                                byte_order_select);
      aisr_pkg::ADDR_Z_LO: rd_mux = sample_byte(lat_z, 1'b0,
                                                byte_order_select);
      aisr_pkg::ADDR_Z_HI: rd_mux = sample_byte(lat_z, 1'b1,
                                                byte_order_select);
      aisr_pkg::ADDR_VECTOR_MAGNITUDE_OUTPUT_LO: rd_mux = sample_byte(lat_vector_magnitude_output, 1'b0,
                                                   byte_order_select);
      aisr_pkg::ADDR_VECTOR_MAGNITUDE_OUTPUT_HI: rd_mux = sample_byte(lat_vector_magnitude_output, 1'b1,
                                                   byte_order_select);
      aisr_pkg::ADDR_SENS_CFG1: rd_mux = {6'h00, trig_sel, activate};
      aisr_pkg::ADDR_SENS_CFG3: rd_mux = {7'h00, byte_order_select};
      aisr_pkg::ADDR_BUF_CFG1: rd_mux = {6'h00, buf_mode};
      aisr_pkg::ADDR_RSVD_A: rd_mux = rsvd_a;
      aisr_pkg::ADDR_RSVD_B: rd_mux = aisr_pkg::RST_RSVD_B;
      default: rd_mux = 8'h00;
    endcase
  end

  // Link level: three stages, change counted once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      smp_sync <= 3'h0;
      smp_level <= 1'b0;
    end
    else if (ce)
    begin
      smp_sync <= {smp_sync[1:0], sample_clk};
      if (smp_agree)
        smp_level <= smp_sync[2];
    end
  end

  // Wake strap caught once, after the release of reset
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      strap_sync <= 3'h0;
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      wake_high <= 1'b0;
    end
    else if (ce)
    begin
      strap_sync <= {strap_sync[1:0], wake_strap};
      if (strap_cnt != aisr_pkg::STRAP_SETTLE_CYC)
        strap_cnt <= strap_cnt + 2'h1;
      else if (!strap_done && strap_sync[1] == strap_sync[2])
      begin
        wake_high <= strap_sync[2];
        strap_done <= 1'b1;
      end
    end
  end

  // Operating mode and control registers
  always_ff @(posedge clk_sys)
  begin
    if (reg_rst)
    begin
      mode <= aisr_pkg::AISR_STANDBY;
      activate <= 1'b0;
      trig_sel <= 1'b0;
      buf_mode <= aisr_pkg::RST_BUF_MODE;
      byte_order_select <= aisr_pkg::RST_BYTE_ORDER;
      rsvd_a <= aisr_pkg::RST_RSVD_A;
      soft_rst <= 1'b0;
    end
    else if (ce)
    begin
      mode <= next_mode;
      soft_rst <= wr_cfg1 & host_wdata[aisr_pkg::BIT_SOFT_RST];
      if (wr_cfg1 && !in_ext)
        activate <= host_wdata[aisr_pkg::BIT_ACTIVATE];
      if (wr_cfg1 && in_standby)
        trig_sel <= host_wdata[aisr_pkg::BIT_TRIG_SEL];
      if (wr_cfg3 && in_standby)
        byte_order_select <= host_wdata[aisr_pkg::BIT_BYTE_ORDER];
      if (wr_buf1 && in_standby)
        buf_mode <= host_wdata[aisr_pkg::BIT_BUF_MODE_HI:
                               aisr_pkg::BIT_BUF_MODE_LO];
      if (wr_rsvd_a && in_standby)
        rsvd_a <= host_wdata;
    end
  end

  // Status flags and latched results
  always_ff @(posedge clk_sys)
  begin
    if (reg_rst)
    begin
      new_sample_flag <= 1'b0;
      sample_overrun_flag <= 1'b0;
      boot_complete_flag <= aisr_pkg::RST_INT_STATUS[aisr_pkg::BIT_BOOT];
      unread_set <= 1'b0;
      lat_x <= 12'h000;
      lat_y <= 12'h000;
      lat_z <= 12'h000;
      lat_vector_magnitude_output <= 12'h000;
      lat_temp <= 8'h00;
    end
    else if (ce)
    begin
      new_sample_flag <= next_new_sample;
      sample_overrun_flag <= next_overrun;
      boot_complete_flag <= next_boot;
      unread_set <= next_unread;
      if (latch_set)
      begin
        lat_x <= accel_x;
        lat_y <= accel_y;
        lat_z <= accel_z;
        lat_vector_magnitude_output <= vector_magnitude_output;
        lat_temp <= temp_data;
      end
    end
  end

  // Host port, pointer and outputs
  always_ff @(posedge clk_sys)
  begin
    if (reg_rst)
    begin
      host_rdata <= 8'h00;
      addr_pointer <= aisr_pkg::ADDR_FIRST;
      int_data_ready <= 1'b0;
      op_mode <= aisr_pkg::AISR_STANDBY;
      buffer_flush <= 1'b0;
      buffer_invalid <= 1'b0;
    end
    else if (ce)
    begin
      if (acc_rd)
        host_rdata <= rd_mux;
      addr_pointer <= next_ptr;
      int_data_ready <= next_irq;
      op_mode <= next_mode;
      buffer_flush <= wr_buf1 & host_wdata[aisr_pkg::BIT_BUF_FLUSH];
      buffer_invalid <= leave_standby;
    end
  end

  aisr_pulse #(
    .WIDTH_CYC(PULSE_CYCLES)
  ) u_pulse (
    .clk_sys(clk_sys),
    .srst(reg_rst),
    .ce(ce),
    .start(pulse_start),
    .stop(enter_standby),
    .pulse_out(pulse_level)
  );
endmodule

// file: test/aisr_chk.sv
// Checker: port properties of the status and mode block
`timescale 1ns/1ps
module aisr_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic hibernate_exit,
  input wire logic wake_strap,
  input wire logic host_addr_load,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic [7:0] addr_pointer,
  input wire logic int_data_ready,
  input wire logic [2:0] op_mode,
  input wire logic byte_order_select,
  input wire logic buffer_flush,
  input wire logic buffer_invalid
);
  logic step;
  assign step = ce && host_rd && !host_addr_load && !hibernate_exit;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  property p_wrap;
    step && addr_pointer == 8'h3A |=> addr_pointer == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
  property p_to_b;
    step && addr_pointer == 8'h39 |=> addr_pointer == 8'h3A;
  endproperty
  a_to_b: assert property (p_to_b) else $error("pointer skipped 3A");
  property p_inc;
    step && !$past(host_wr) && addr_pointer != 8'h39 && addr_pointer != 8'h3A
      |=> addr_pointer == $past(addr_pointer) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer not advanced");
  property p_rst;
    $fell(srst) |-> addr_pointer == 8'h00 && host_rdata == 8'h00 &&
      op_mode == 3'b001 && !int_data_ready && !byte_order_select;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_inv;
    op_mode != 3'b001 && $past(op_mode) == 3'b001 |-> ##[0:1] buffer_invalid;
  endproperty
  a_inv: assert property (p_inv) else $error("no invalid pulse");
  property p_inv1;
    buffer_invalid |=> !buffer_invalid;
  endproperty
  a_inv1: assert property (p_inv1) else $error("invalid too long");
  property p_flush;
    ce && host_wr && addr_pointer == 8'h26 && host_wdata[7] && !hibernate_exit
      |-> ##[1:2] buffer_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush pulse");
  property p_ext;
    (op_mode == 3'b100 && !host_wr && !hibernate_exit) [*2]
      |=> op_mode == 3'b100;
  endproperty
  a_ext: assert property (p_ext) else $error("trigger state left");
  property p_bo;
    (op_mode != 3'b001 && !host_wr && !hibernate_exit) [*2]
      |=> $stable(byte_order_select);
  endproperty
  a_bo: assert property (p_bo) else $error("byte order changed");
  property p_pend;
    wake_strap && op_mode == 3'b001 && $past(op_mode) != 3'b001
      |-> ##[0:1] !int_data_ready;
  endproperty
  a_pend: assert property (p_pend) else $error("pulse not ended");
endmodule
bind aisr_top aisr_chk u_chk (.clk_sys(clk_sys), .srst(srst), .ce(ce),
  .hibernate_exit(hibernate_exit), .wake_strap(wake_strap),
  .host_addr_load(host_addr_load), .host_rd(host_rd), .host_wr(host_wr),
  .host_wdata(host_wdata), .host_rdata(host_rdata),
  .addr_pointer(addr_pointer), .int_data_ready(int_data_ready),
  .op_mode(op_mode), .byte_order_select(byte_order_select),
  .buffer_flush(buffer_flush), .buffer_invalid(buffer_invalid));

// file: test/aisr_host_model.sv
// Host model: register port transfers from the controller side
`timescale 1ns/1ps
module aisr_host_model (
  input wire logic clk_sys,
  output logic host_addr_load,
  output logic [7:0] host_addr,
  output logic host_rd,
  output logic host_wr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  initial
  begin
    host_addr_load = 1'b0;
    host_addr = 8'h5A;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 8'hA5;
  end
  // Released lines show the inverse, not the last value
  task automatic load(input logic [7:0] a);
    @(posedge clk_sys);
    host_addr_load <= 1'b1;
    host_addr <= a;
    @(posedge clk_sys);
    host_addr_load <= 1'b0;
    host_addr <= ~a;
  endtask
  task automatic rd(output logic [7:0] d);
    host_rd <= 1'b1;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    @(posedge clk_sys);
    d = host_rdata;
  endtask
  task automatic wr(input logic [7:0] v);
    host_wr <= 1'b1;
    host_wdata <= v;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    host_wdata <= ~v;
  endtask
endmodule

// file: test/aisr_top_tb.sv
// Testbench: status flags, mode control and register tail
`timescale 1ns/1ps
module aisr_top_tb;
  localparam int PW = 20;
  logic clk_sys, srst, ce, hib, strap, sclk, buf_ev, ld, rd, wr;
  logic int_dr, bo, fl, inv;
  logic [3:0] flg;
  logic [11:0] ax;
  logic [7:0] addr, wdat, rdat, ptr, d;
  logic [2:0] mode;
  int n_fail, n_compared, cyc, n;
  aisr_top #(.PULSE_CYCLES(PW)) uut (.clk_sys(clk_sys), .srst(srst),
    .ce(ce), .hibernate_exit(hib), .wake_strap(strap), .sample_clk(sclk),
    .accel_x(ax), .accel_y(12'h123), .accel_z(12'h456),
    .vector_magnitude_output(12'h789), .temp_data(8'h19),
    .buffer_event_in(buf_ev), .outside_threshold_in(flg[3]),
    .within_threshold_in(flg[2]), .orientation_change_in(flg[1]),
    .auto_sleep_in(flg[0]), .host_addr_load(ld), .host_addr(addr),
    .host_rd(rd), .host_wr(wr), .host_wdata(wdat), .host_rdata(rdat),
    .addr_pointer(ptr), .int_data_ready(int_dr), .op_mode(mode),
    .byte_order_select(bo), .buffer_flush(fl), .buffer_invalid(inv));
  aisr_host_model hm (.clk_sys(clk_sys), .host_addr_load(ld),
    .host_addr(addr), .host_rd(rd), .host_wr(wr), .host_wdata(wdat),
    .host_rdata(rdat));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    hm.load(a);
    hm.rd(d);
    chk(d, exp);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    hm.load(a);
    hm.wr(v);
  endtask
  task automatic act(input logic [7:0] v);
    wrr(8'h15, v);
    repeat (2) @(posedge clk_sys);
  endtask
  // One link frame: the link clock idles low between frames
  task automatic sample(input int w);
    sclk <= 1'b1;
    fork
      begin
        repeat (4) @(posedge clk_sys);
        sclk <= 1'b0;
      end
    join_none
    repeat (w + 1) @(posedge clk_sys);
  endtask
  task automatic wait_int();
    for (int i = 0; i < 40 && int_dr !== 1'b1; i++)
      @(posedge clk_sys);
  endtask
  task automatic do_reset(input logic s);
    strap <= s;
    srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    rdc(8'h00, 8'h01);
    wrr(8'h00, 8'hFF);
    rdc(8'h00, 8'h00);
    wrr(8'h39, 8'h00);
    rdc(8'h39, 8'h00);
    chk(ptr, 8'h3A);
    hm.rd(d);
    chk(ptr, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      flg <= 4'(1 << k);
      rdc(8'h00, 8'(2 << k));
    end
    flg <= 4'h0;
  endtask
  // Clock enable low: load and read are not taken
  task automatic t_freeze();
    hm.load(8'h05);
    ce <= 1'b0;
    hm.load(8'h09);
    hm.rd(d);
    chk(ptr, 8'h05);
    ce <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic t_order();
    wrr(8'h17, 8'h01);
    @(posedge clk_sys);
    chk(8'(bo), 8'h01);
    act(8'h01);
    chk(8'(mode), 8'(aisr_pkg::AISR_ACTIVE));
    chk(8'(inv), 8'h01);
    sample(12);
    rdc(8'h04, 8'hAB);
    wrr(8'h17, 8'h00);
    act(8'h00);
    chk(8'(bo), 8'h01);
    wrr(8'h17, 8'h00);
    @(posedge clk_sys);
    chk(8'(bo), 8'h00);
  endtask
  task automatic t_flags();
    act(8'h01);
    sample(12);
    chk(8'(int_dr), 8'h01);
    rdc(8'h00, 8'h80);
    rdc(8'h04, 8'hBC);
    @(posedge clk_sys);
    chk(8'(int_dr), 8'h00);
    rdc(8'h00, 8'h00);
    sample(12);
    sample(12);
    rdc(8'h00, 8'hC0);
    rdc(8'h00, 8'h80);
    rdc(8'h06, 8'h23);
    sample(12);
    rdc(8'h00, 8'h80);
    act(8'h00);
    rdc(8'h00, 8'h80);
    act(8'h01);
    rdc(8'h00, 8'h00);
    act(8'h00);
  endtask
  task automatic t_buffer();
    wrr(8'h26, 8'h01);
    buf_ev <= 1'b1;
    act(8'h01);
    sample(12);
    sample(12);
    rdc(8'h00, 8'h20);
    wrr(8'h26, 8'h80);
    @(posedge clk_sys);
    chk(8'(fl), 8'h01);
    buf_ev <= 1'b0;
    act(8'h00);
    wrr(8'h26, 8'h00);
  endtask
  task automatic t_ext();
    wrr(8'h17, 8'h01);
    act(8'h03);
    chk(8'(mode), 8'(aisr_pkg::AISR_EXTERNAL_TRIGGER_STATE));
    act(8'h00);
    chk(8'(mode), 8'(aisr_pkg::AISR_EXTERNAL_TRIGGER_STATE));
    act(8'h80);
    chk(8'(mode), 8'(aisr_pkg::AISR_STANDBY));
    chk(8'(bo), 8'h00);
    wrr(8'h17, 8'h01);
    hib <= 1'b1;
    @(posedge clk_sys);
    hib <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(8'(bo), 8'h00);
    rdc(8'h00, 8'h01);
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    act(8'h01);
    sample(0);
    wait_int();
    n = 0;
    while (int_dr === 1'b1 && n < 99)
    begin
      n++;
      @(posedge clk_sys);
    end
    chk(8'(n), 8'(PW));
    rdc(8'h00, 8'h80);
    sample(0);
    wait_int();
    repeat (3) @(posedge clk_sys);
    act(8'h00);
    @(posedge clk_sys);
    chk(8'(int_dr), 8'h00);
  endtask
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    hib = 1'b0;
    strap = 1'b0;
    sclk = 1'b0;
    buf_ev = 1'b0;
    flg = 4'h0;
    ax = 12'hABC;
    cyc = 0;
    n_fail = 0;
    n_compared = 0;
    do_reset(1'b0);
    t_regs();
    t_freeze();
    t_order();
    t_flags();
    t_buffer();
    t_ext();
    t_strap();
    end_of_test();
  end
endmodule
